// *** shared/dual_timer_consts.svh ***
// Register offsets, field positions, reset values and encodings of the dual timer.
`ifndef DUAL_TIMER_CONSTS_SVH
`define DUAL_TIMER_CONSTS_SVH

// Byte addresses of the register words.
`define OFF_LOWER_CTRL 8'h00
`define OFF_UPPER_CTRL 8'h04
`define OFF_LOWER_PERIOD 8'h08
`define OFF_UPPER_PERIOD 8'h0C
`define OFF_LOWER_DUTY 8'h10
`define OFF_UPPER_DUTY 8'h14
`define OFF_COUNT 8'h18
`define OFF_INT_STATUS 8'h1C
`define OFF_INT_MASK 8'h20
`define OFF_POWER_CFG 8'h24

// Control register fields.
`define CTRL_FF_BIT 7
`define CTRL_CLK_HI 6
`define CTRL_CLK_LO 4
`define CTRL_START_BIT 3
`define CTRL_MODE_HI 2
`define CTRL_MODE_LO 0

// Power configuration fields.
`define CFG_TAP_BIT 0
`define CFG_SLOW_BIT 1

// Reset values.
`define RST_CTRL 8'h00
`define RST_PERIOD 8'h00
`define RST_DUTY 8'h00
`define RST_CFG 2'h0
`define RST_INT 2'h0

// Mode codes.
`define MODE_TIMER 3'h0
`define MODE_DIVIDER 3'h1
`define MODE_PWM 3'h2
`define MODE_CASCADE 3'h3

// Clock select codes.
`define CLK_SLOW_TAP 3'h0
`define CLK_DIV7 3'h1
`define CLK_DIV5 3'h2
`define CLK_DIV3 3'h3
`define CLK_LOW_FREQ 3'h4
`define CLK_DIV1 3'h5
`define CLK_FULL 3'h6
`define CLK_PIN 3'h7

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** shared/dual_timer_pkg.sv ***
// Types shared by the dual timer modules.
package dual_timer_pkg;

  // State of one 8-bit counting unit.
  typedef struct packed {
    logic [7:0] count;
  } unit_state_t;

  // State of the timer pair and its register slave.
  typedef struct packed {
    logic [7:0] lower_ctrl;
    logic [7:0] upper_ctrl;
    logic [7:0] lower_period;
    logic [7:0] upper_period;
    logic [7:0] lower_duty;
    logic [7:0] upper_duty;
    logic [1:0] power_cfg;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [10:0] prescaler;
    logic [2:0] low_div;
    logic [1:0] pin_prev;
    logic lower_ff;
    logic upper_ff;
    logic lower_start_prev;
    logic upper_start_prev;
    logic lower_irq_pulse;
    logic upper_irq_pulse;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_state_t;

endpackage

// *** shared/timer_unit_if.sv ***
// Signals between the timer pair control and one 8-bit counting unit.
`timescale 1ns/100ps
`default_nettype none
interface timer_unit_if;
  logic tick;
  logic run;
  logic self_cmp;
  logic clear;
  logic [7:0] period;
  logic [7:0] count;
  logic match;
  logic carry;

  modport unit (input tick, run, self_cmp, clear, period, output count, match, carry);
  modport ctrl (output tick, run, self_cmp, clear, period, input count, match, carry);
endinterface
`default_nettype wire

// *** hdl/timer_unit.sv ***
// One 8-bit up-counting unit with period compare and overflow carry.
`timescale 1ns/100ps
`default_nettype none
module timer_unit (
  input wire logic aclk,
  input wire logic aresetn,
  timer_unit_if.unit port_if
);
  dual_timer_pkg::unit_state_t state_reg;
  dual_timer_pkg::unit_state_t state_next;
  logic [7:0] count_inc;

  assign count_inc = state_reg.count + 8'h01;

  // A match is taken on the tick that would bring the count to the period.
  assign port_if.match = port_if.run & port_if.tick & port_if.self_cmp &
                         (count_inc == port_if.period);
  // Overflow from 0xFF feeds the upper unit in cascaded operation.
  assign port_if.carry = port_if.run & port_if.tick & (state_reg.count == 8'hFF);
  assign port_if.count = state_reg.count;

  // Stopped units hold zero; a match or an external clear restarts from zero.
  always_comb begin
    state_next = state_reg;
    if (!port_if.run || port_if.clear) begin
      state_next.count = 8'h00;
    end else if (port_if.match) begin
      state_next.count = 8'h00;
    end else if (port_if.tick) begin
      state_next.count = count_inc;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

// *** hdl/dual_timer.sv ***
// Cascadable pair of 8-bit timer/counters with an AXI4-Lite register slave.
// Operation
// - Upper byte cascade clocks on lower overflow.
// - Cascade uses lower clock, upper start and init.
// - Units support timer, divider and 16-bit cascade modes; PWM mode and the duty registers have no logic.
// - Timer counts, matches period, interrupts, clears.
// - Period writes take effect at once.
// - Clock select code maps to prescaler taps.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`include "dual_timer_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dual_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_freq_tick,
  input wire logic lower_pin,
  input wire logic upper_pin,
  output logic lower_match_interrupt,
  output logic upper_match_interrupt,
  output logic lower_divider_output_pin,
  output logic upper_divider_output_pin,
  output logic irq
);
  dual_timer_pkg::top_state_t state_reg;
  dual_timer_pkg::top_state_t state_next;
  timer_unit_if lower_if ();
  timer_unit_if upper_if ();

  logic low8_tick;
  logic lower_fall;
  logic upper_fall;
  logic cascade;
  logic upper_start;
  logic [15:0] count16_inc;
  logic match16;
  logic lower_event;
  logic upper_event;
  logic wr_fire;
  logic rd_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Tells whether a byte address is one of the register words.
  function automatic logic addr_ok(input logic [7:0] addr);
    addr_ok = (addr[1:0] == 2'h0) && (addr <= `OFF_POWER_CFG);
  endfunction

  // Picks the counting tick for a clock select code.
  function automatic logic src_tick(input logic [2:0] sel, input logic [10:0] pre,
                                    input logic slow_tap, input logic low8,
                                    input logic low1, input logic pin_fall);
    case (sel)
      `CLK_SLOW_TAP: src_tick = slow_tap ? low8 : (pre == 11'h7FF);
      `CLK_DIV7: src_tick = (pre[6:0] == 7'h7F);
      `CLK_DIV5: src_tick = (pre[4:0] == 5'h1F);
      `CLK_DIV3: src_tick = (pre[2:0] == 3'h7);
      `CLK_LOW_FREQ: src_tick = low1;
      `CLK_DIV1: src_tick = pre[0];
      `CLK_FULL: src_tick = 1'b1;
      default: src_tick = pin_fall;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Counting units.

  timer_unit lower_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .port_if(lower_if)
  );

  timer_unit upper_unit (
    .aclk(aclk),
    .aresetn(aresetn),
    .port_if(upper_if)
  );

  // Source ticks: the low-frequency clock divided by eight and pin falling edges.
  assign low8_tick = low_freq_tick & (state_reg.low_div == 3'h7);
  assign lower_fall = state_reg.pin_prev[0] & ~lower_pin;
  assign upper_fall = state_reg.pin_prev[1] & ~upper_pin;

  // Cascade when lower is in mode 011 and upper selects an upper-byte mode.
  assign cascade = (state_reg.lower_ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_CASCADE) &&
                   state_reg.upper_ctrl[`CTRL_MODE_HI];
  assign upper_start = state_reg.upper_ctrl[`CTRL_START_BIT];

  // Unit steering; periods are read straight from the registers.
  assign lower_if.run = cascade ? upper_start : state_reg.lower_ctrl[`CTRL_START_BIT];
  assign upper_if.run = upper_start;
  assign lower_if.tick = src_tick(state_reg.lower_ctrl[`CTRL_CLK_HI:`CTRL_CLK_LO],
                                  state_reg.prescaler,
                                  state_reg.power_cfg[`CFG_TAP_BIT] |
                                  state_reg.power_cfg[`CFG_SLOW_BIT],
                                  low8_tick, low_freq_tick, lower_fall);
  assign upper_if.tick = cascade ? lower_if.carry :
                         src_tick(state_reg.upper_ctrl[`CTRL_CLK_HI:`CTRL_CLK_LO],
                                  state_reg.prescaler,
                                  state_reg.power_cfg[`CFG_TAP_BIT] |
                                  state_reg.power_cfg[`CFG_SLOW_BIT],
                                  low8_tick, low_freq_tick, upper_fall);
  assign lower_if.self_cmp = ~cascade;
  assign upper_if.self_cmp = ~cascade;
  assign lower_if.period = state_reg.lower_period;
  assign upper_if.period = state_reg.upper_period;

  // The 16-bit compare runs on the lower tick and clears both bytes.
  assign count16_inc = {upper_if.count, lower_if.count} + 16'h0001;
  assign match16 = cascade && upper_start && lower_if.tick &&
                   (count16_inc == {state_reg.upper_period, state_reg.lower_period});
  assign lower_if.clear = match16;
  assign upper_if.clear = match16;
  assign lower_event = lower_if.match;
  assign upper_event = cascade ? match16 : upper_if.match;

  // Register bus handshake terms.
  assign wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
  assign rd_fire = s_axi_arvalid && !state_reg.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    state_next = state_reg;
    state_next.prescaler = state_reg.prescaler + 11'h001;
    state_next.low_div = state_reg.low_div + {2'h0, low_freq_tick};
    state_next.pin_prev = {upper_pin, lower_pin};
    state_next.lower_start_prev = lower_if.run;
    state_next.upper_start_prev = upper_start;

    // Output flip-flops load their init bit on start and toggle in divider mode.
    if (lower_if.run && !state_reg.lower_start_prev) begin
      state_next.lower_ff = cascade ? state_reg.upper_ctrl[`CTRL_FF_BIT]
                                    : state_reg.lower_ctrl[`CTRL_FF_BIT];
    end else if (lower_event &&
                 state_reg.lower_ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_DIVIDER) begin
      state_next.lower_ff = ~state_reg.lower_ff;
    end
    if (upper_start && !state_reg.upper_start_prev) begin
      state_next.upper_ff = state_reg.upper_ctrl[`CTRL_FF_BIT];
    end else if (upper_event && !cascade &&
                 state_reg.upper_ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_DIVIDER) begin
      state_next.upper_ff = ~state_reg.upper_ff;
    end

    // Match pulses last one cycle each.
    state_next.lower_irq_pulse = lower_event;
    state_next.upper_irq_pulse = upper_event;

    // Write address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata[7:0];
      state_next.wstrb0 = s_axi_wstrb[0];
    end

    // Register write once both halves are held.
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = addr_ok(state_reg.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (state_reg.wstrb0) begin
        case (state_reg.awaddr)
          `OFF_LOWER_CTRL: state_next.lower_ctrl = state_reg.wdata;
          `OFF_UPPER_CTRL: state_next.upper_ctrl = state_reg.wdata;
          `OFF_LOWER_PERIOD: state_next.lower_period = state_reg.wdata;
          `OFF_UPPER_PERIOD: state_next.upper_period = state_reg.wdata;
          `OFF_LOWER_DUTY: state_next.lower_duty = state_reg.wdata;
          `OFF_UPPER_DUTY: state_next.upper_duty = state_reg.wdata;
          `OFF_INT_STATUS: state_next.int_status = state_reg.int_status & ~state_reg.wdata[1:0];
          `OFF_INT_MASK: state_next.int_mask = state_reg.wdata[1:0];
          `OFF_POWER_CFG: state_next.power_cfg = state_reg.wdata[1:0];
          default: state_next.bresp = state_reg.bvalid ? state_reg.bresp : state_next.bresp;
        endcase
      end
    end else if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Sticky status bits; a new match wins over a clear in the same cycle.
    state_next.int_status = state_next.int_status | {upper_event, lower_event};

    // Register read, answered one cycle after the address is taken.
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFF_LOWER_CTRL: state_next.rdata = {24'h000000, state_reg.lower_ctrl};
        `OFF_UPPER_CTRL: state_next.rdata = {24'h000000, state_reg.upper_ctrl};
        `OFF_LOWER_PERIOD: state_next.rdata = {24'h000000, state_reg.lower_period};
        `OFF_UPPER_PERIOD: state_next.rdata = {24'h000000, state_reg.upper_period};
        `OFF_LOWER_DUTY: state_next.rdata = {24'h000000, state_reg.lower_duty};
        `OFF_UPPER_DUTY: state_next.rdata = {24'h000000, state_reg.upper_duty};
        `OFF_COUNT: state_next.rdata = {16'h0000, upper_if.count, lower_if.count};
        `OFF_INT_STATUS: state_next.rdata = {30'h00000000, state_reg.int_status};
        `OFF_INT_MASK: state_next.rdata = {30'h00000000, state_reg.int_mask};
        `OFF_POWER_CFG: state_next.rdata = {30'h00000000, state_reg.power_cfg};
        default: state_next.rdata = 32'h00000000;
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.lower_ctrl <= `RST_CTRL;
      state_reg.upper_ctrl <= `RST_CTRL;
      state_reg.lower_period <= `RST_PERIOD;
      state_reg.upper_period <= `RST_PERIOD;
      state_reg.lower_duty <= `RST_DUTY;
      state_reg.upper_duty <= `RST_DUTY;
      state_reg.power_cfg <= `RST_CFG;
      state_reg.int_status <= `RST_INT;
      state_reg.int_mask <= `RST_INT;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign lower_match_interrupt = state_reg.lower_irq_pulse;
  assign upper_match_interrupt = state_reg.upper_irq_pulse;
  // The divider pins show the inverse of the output flip-flops.
  assign lower_divider_output_pin = ~state_reg.lower_ff;
  assign upper_divider_output_pin = ~state_reg.upper_ff;
  assign irq = |(state_reg.int_status & state_reg.int_mask);
endmodule
`default_nettype wire

// *** test/dual_timer_props.sv ***
// Port-level assertions for the cascadable dual timer.
`include "dual_timer_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dual_timer_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lower_match_interrupt,
  input wire logic upper_match_interrupt,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Handshake steps of one write and one read.
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_write_answer;
    s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_bad_write;
    s_wr_both ##0 (s_axi_awaddr > `OFF_POWER_CFG || s_axi_awaddr[1:0] != 2'h0)
      |=> ##1 s_axi_bresp == `RESP_SLVERR;
  endproperty
  property p_read_answer;
    s_rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_bad_read;
    s_rd_take ##0 (s_axi_araddr > `OFF_POWER_CFG || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  // The interrupt only rises with a match pulse or with a register write.
  property p_irq_cause;
    $rose(irq) |-> lower_match_interrupt || upper_match_interrupt || $rose(s_axi_bvalid);
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");
  a_bad_write: assert property (p_bad_write) else $error("bad write not refused");
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  a_bad_read: assert property (p_bad_read) else $error("bad read not refused");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_refuse: assert property (p_refuse) else $error("write taken while busy");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
endmodule
bind dual_timer dual_timer_props props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .lower_match_interrupt, .upper_match_interrupt, .irq);
`default_nettype wire

// *** test/test_dual_timer.sv ***
// Self-checking bench for the cascadable dual timer.
`include "dual_timer_consts.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_dual_timer;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick, pin_lo, pin_hi;
  logic awready, wready, bvalid, arready, rvalid, m_lo, m_hi, div_lo, div_hi, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int fails, n_compared, cyc, n;

  dual_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_freq_tick(tick), .lower_pin(pin_lo),
    .upper_pin(pin_hi), .lower_match_interrupt(m_lo), .upper_match_interrupt(m_hi),
    .lower_divider_output_pin(div_lo), .upper_divider_output_pin(div_hi), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Free-running 4 ns clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Slow ticks every 16 cycles, pin falls every 8 and 16 cycles, and the run limit.
  always @(posedge aclk) begin
    cyc++;
    tick <= (cyc[3:0] == 4'hF);
    pin_lo <= cyc[2];
    pin_hi <= cyc[3];
    if (cyc > 40000) begin
      fails++;
      finish_test();
    end
  end

  // One register transfer; each valid drops when taken, ready drops with the answer.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        r = bresp;
      end
      if (rready && rvalid) begin
        rready <= 1'b0;
        q = rdata;
        r = rresp;
      end
    end while ((bready && !bvalid) || (rready && !rvalid));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi(1'b1, a, d);
    `CHECK(r, `RESP_OKAY)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axi(1'b0, a, 32'h0);
    `CHECK(q, e)
  endtask

  // Counts the cycles from one match pulse of a unit to its next one.
  task automatic gap(input logic up, output int k);
    k = 0;
    while ((up ? m_hi : m_lo) !== 1'b1) @(posedge aclk);
    do begin
      @(posedge aclk);
      k++;
    end while ((up ? m_hi : m_lo) !== 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, then refused addresses.
  task automatic t_regs();
    for (int i = 0; i <= 8'h24; i += 4) rd(i[7:0], 32'h0);
    axi(1'b0, 8'h28, 32'h0);
    `CHECK(r, `RESP_SLVERR)
    `CHECK(q, 32'h0)
    axi(1'b1, 8'h02, 32'h1);
    `CHECK(r, `RESP_SLVERR)
  endtask

  // Every clock select code of the lower unit with a period of four, fast then slow.
  task automatic t_clocks();
    logic [2:0] code [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h6};
    int f [8] = '{128, 128, 32, 8, 16, 2, 8, 1};
    logic [31:0] w;
    wr(`OFF_POWER_CFG, 32'h1);
    wr(`OFF_LOWER_PERIOD, 32'h4);
    wr(`OFF_LOWER_DUTY, 32'h80);
    for (int i = 0; i < 8; i++) begin
      // Codes 0 to 3 and the pin run as timer, codes 4 to 6 (low frequency, divide-by-one, full) as PWM.
      w = {24'h0, 1'b0, code[i], 1'b1,
           (code[i] inside {3'h4, 3'h5, 3'h6}) ? 3'h2 : 3'h0};
      wr(`OFF_LOWER_CTRL, w);
      gap(1'b0, n);
      `CHECK(n, 4 * f[i])
      wr(`OFF_LOWER_CTRL, w & 32'hF7);
    end
    // Low-speed mode: only the slow tap and the pin are used.
    wr(`OFF_POWER_CFG, 32'h2);
    for (int i = 0; i < 8; i += 6) begin
      w = {24'h0, 1'b0, code[i], 4'h8};
      wr(`OFF_LOWER_CTRL, w);
      gap(1'b0, n);
      `CHECK(n, 4 * f[i])
      wr(`OFF_LOWER_CTRL, w & 32'hF7);
    end
    wr(`OFF_POWER_CFG, 32'h1);
  endtask

  // Interrupt raised, masked and cleared; stopping clears and halts the count.
  task automatic t_irq();
    wr(`OFF_INT_MASK, 32'h1);
    wr(`OFF_LOWER_CTRL, 32'h38);
    gap(1'b0, n);
    `CHECK(irq, 1'b1)
    wr(`OFF_LOWER_CTRL, 32'h30);
    rd(`OFF_COUNT, 32'h0);
    rd(`OFF_INT_STATUS, 32'h1);
    wr(`OFF_INT_MASK, 32'h0);
    `CHECK(irq, 1'b0)
    wr(`OFF_INT_MASK, 32'h1);
    `CHECK(irq, 1'b1)
    wr(`OFF_INT_STATUS, 32'h1);
    `CHECK(irq, 1'b0)
    n = 0;
    repeat (100) begin
      @(posedge aclk);
      if (m_lo === 1'b1) n++;
    end
    `CHECK(n, 0)
  endtask

  // A period rewritten while running applies at once.
  task automatic t_live();
    wr(`OFF_LOWER_PERIOD, 32'hFA);
    wr(`OFF_LOWER_CTRL, 32'h38);
    wr(`OFF_LOWER_PERIOD, 32'h14);
    n = 0;
    while (m_lo !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
    `CHECK(n < 192, 1'b1)
    gap(1'b0, n);
    `CHECK(n, 160)
    wr(`OFF_LOWER_CTRL, 32'h30);
  endtask

  // Cascade: the lower select clocks it, the upper start runs it, only the upper pulses.
  task automatic t_cascade();
    wr(`OFF_LOWER_PERIOD, 32'h0);
    wr(`OFF_UPPER_PERIOD, 32'h2);
    wr(`OFF_LOWER_CTRL, 32'h33);
    wr(`OFF_INT_STATUS, 32'h3);
    // The upper select names the pin, which the cascade must ignore; timer, not pulse mode.
    wr(`OFF_UPPER_CTRL, 32'h7C);
    gap(1'b1, n);
    `CHECK(n, 4096)
    rd(`OFF_INT_STATUS, 32'h2);
    wr(`OFF_UPPER_CTRL, 32'h78);
  endtask

  // Reset, then each scenario in turn.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tick, pin_lo, pin_hi} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_clocks();
    t_irq();
    t_live();
    t_cascade();
    finish_test();
  end
endmodule
`default_nettype wire
